// File: dv/boot_sequencer_image_locator_test.sv
// self-checking bench for the boot sequencer and image locator
// assumes bsl_pkg compiled first and the flash model beside the sequencer
`timescale 1ns/1ps
`default_nettype none
module boot_sequencer_image_locator_test;
  import bsl_pkg::*;
  localparam logic [31:0] SIG   = 32'hA5C3_5A3C;  // arbitrary marker value
  localparam int          LIMIT = 20000;          // cycle ceiling for the run

  logic           core_clk, reset_n, sel, lpr;    // clock, reset, pins
  bsl_supply_t    sup;                            // supply levels
  logic [1:0]     straps;                         // address straps
  logic [3:0]     lat;                            // flash answer delay
  bsl_flash_req_t freq;                           // read request
  bsl_flash_rsp_t frsp;                           // read answer
  bsl_periph_en_t pen;                            // peripheral enables
  logic           core_reset, regs_reset, trim_load, clk48_en, slow_sel;
  logic           host_en, dead_bat, path_bus, region_high, boot_done;
  logic           inval, dbg_en;
  logic [6:0]     taddr;                          // target address
  logic [23:0]    fw_base;                        // firmware start
  logic [31:0]    seed;                           // random state
  int             errors, compares, cycles;       // tallies

  bsl_boot_seq #(.APP_SIGNATURE(SIG), .PERSIST(4), .TRIM_WAIT(2)) uut (
    .core_clk(core_clk), .reset_n(reset_n), .supplies(sup),
    .address_strap_pins(straps), .bus_power_path_select(sel),
    .low_power_req(lpr), .flash_rsp(frsp), .core_reset(core_reset),
    .regs_reset(regs_reset), .trim_load(trim_load), .clk48_en(clk48_en),
    .slow_clk_sel(slow_sel), .periph_en(pen), .target_address(taddr),
    .host_if_en(host_en), .dead_battery(dead_bat), .power_path_bus(path_bus),
    .flash_req(freq), .fw_base(fw_base), .region_high(region_high),
    .boot_done(boot_done), .invalid_memory(inval), .debug_wire_en(dbg_en));

  bsl_flash_model fm (.core_clk(core_clk), .reset_n(reset_n), .lat(lat),
    .flash_req(freq), .flash_rsp(frsp));

  // free-running clock, 8 ns period
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  // a region is usable when its pointer is neither blank nor null and its marker is good
  function automatic logic usable(input logic [23:0] p, input logic good);
    return p != 24'hFF_FFFF && p != 24'h00_0000 && good;
  endfunction

  // inputs change one step after the rising edge; outputs are settled there
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic put_hdr(input logic [23:0] b, p, o, input logic good);
    fm.mem[b]         = {8'h00, p};
    fm.mem[b + 24'h4] = {8'h00, o};
    if (p != 24'hFF_FFFF && p != 24'h00_0000)
      fm.mem[p + o] = good ? SIG : ~SIG;
  endtask

  // one full boot from reset with a given supply state and flash image
  task automatic run(input int id, input logic mv, bv, input logic [23:0] lp, lo,
                     input logic lg, input logic [23:0] hp, ho, input logic hg);
    logic [31:0] r;
    logic        lo_ok, hi_ok, saw_hi;
    int          i;
    fm.mem.delete();
    put_hdr(24'h00_0000, lp, lo, lg);
    put_hdr(24'h00_1000, hp, ho, hg);
    r      = rnd();
    straps = r[1:0];
    sel    = r[2];
    lat    = r[7:4];
    lpr    = 1'b0;
    saw_hi = 1'b0;
    lo_ok  = usable(lp, lg);
    hi_ok  = usable(hp, hg);
    reset_n = 1'b0;
    sup     = {1'b0, mv, bv};
    repeat (10) tick();
    reset_n = 1'b1;
    tick();
    tick();
    check_flag(core_reset, 1'b1);
    sup.regulator_ok = 1'b1;
    for (i = 0; i < 20 && regs_reset !== 1'b1; i++) tick();
    check_flag(core_reset, 1'b0);
    check_flag(regs_reset, 1'b1);
    check_flag(trim_load, 1'b0);
    tick();
    check_flag(trim_load, 1'b1);
    check_flag(regs_reset, 1'b0);
    if (!mv && !bv) begin
      // no supply ever stable: sequence parks after the fast clock
      repeat (60) tick();
      check_flag(clk48_en, 1'b1);
      check_val(pen, 32'h0000_0000);
      check_flag(host_en, 1'b0);
    end else begin
      for (i = 0; i < 200 && freq.req !== 1'b1; i++) tick();
      check_val(pen, 32'h0000_003F);
      check_flag(host_en, 1'b1);
      check_val(taddr, {25'h0, 2'b01, straps, 3'b111});
      check_flag(dead_bat, !mv && bv);
      check_flag(path_bus, !mv && bv && !sel);
      check_val(freq.addr, 32'h0000_0000);
      for (i = 0; i < 600 && boot_done !== 1'b1 && inval !== 1'b1; i++) begin
        if (freq.req === 1'b1 && freq.addr === 24'h00_1000)
          saw_hi = 1'b1;
        tick();
      end
      check_flag(saw_hi, !lo_ok);
      check_flag(freq.req, 1'b0);
      check_flag(boot_done, lo_ok || hi_ok);
      check_flag(inval, !lo_ok && !hi_ok);
      check_flag(dbg_en, !lo_ok && !hi_ok);
      if (lo_ok || hi_ok) begin
        check_flag(region_high, !lo_ok);
        check_val(fw_base, lo_ok ? lp + lo : hp + ho);
        lpr = 1'b1;
        repeat (3) tick();
        check_flag(slow_sel, 1'b1);
        check_flag(clk48_en, 1'b0);
      end
    end
    // regulator loss drops the boot back to reset; target address and firmware base keep their values
    sup.regulator_ok = 1'b0;
    tick();
    tick();
    check_flag(core_reset, 1'b1);
    check_flag(boot_done, 1'b0);
    $display("test %0d done", id);
  endtask

  initial begin
    logic [31:0] a, b;
    reset_n  = 1'b0;
    sup      = '0;
    straps   = 2'h0;
    sel      = 1'b0;
    lpr      = 1'b0;
    lat      = 4'h0;
    seed     = 32'h3029_6be0;
    errors   = 0;
    compares = 0;
    cycles   = 0;
    run(0, 1'b1, 1'b0, 24'h20_0000, 24'h00_0100, 1'b1, 24'h60_0000, 24'h00_0200, 1'b1);
    run(1, 1'b1, 1'b1, 24'hFF_FFFF, 24'h00_0100, 1'b1, 24'h60_0400, 24'h00_0010, 1'b1);
    run(2, 1'b0, 1'b1, 24'h20_0800, 24'h00_0040, 1'b0, 24'h60_0000, 24'h00_0FFC, 1'b1);
    run(3, 1'b0, 1'b1, 24'h00_0000, 24'h00_0100, 1'b1, 24'h61_0000, 24'h00_0020, 1'b0);
    run(4, 1'b0, 1'b0, 24'h20_0000, 24'h00_0100, 1'b1, 24'h60_0000, 24'h00_0200, 1'b1);
    for (int k = 5; k < 13; k++) begin
      a = rnd();
      b = rnd();
      run(k, a[28], a[29] | ~a[28],
          a[27] ? 24'hFF_FFFF : {4'h2, a[19:2], 2'b00}, {12'h000, b[11:2], 2'b00},
          a[30], {4'h6, b[31:14], 2'b00}, {12'h000, a[11:2], 2'b00}, a[31]);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire

// File: dv/bsl_flash_model.sv
// flash word reader partner: answers word reads from a sparse flash image
// assumes the sequencer holds each request until it sees the answer pulse
`timescale 1ns/1ps
`default_nettype none
module bsl_flash_model
  import bsl_pkg::*;
(
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire logic [3:0]              lat,
  input  wire bsl_pkg::bsl_flash_req_t flash_req,
  output var  bsl_pkg::bsl_flash_rsp_t flash_rsp
);
  logic [31:0] mem [logic [23:0]];  // sparse image, unset words read erased
  logic [3:0]  cnt;                 // cycles left before the answer
  logic        busy;                // a request has been taken

  // one answer per request; data scrambles every cycle outside an answer
  always @(posedge core_clk) begin
    if (!reset_n) begin
      flash_rsp <= '0;
      busy      <= 1'b0;
      cnt       <= 4'h0;
    end else if (flash_rsp.valid) begin
      // answer stands one cycle only, mode 0 link behind the reader
      flash_rsp.valid <= 1'b0;
      flash_rsp.data  <= ~flash_rsp.data;
    end else if (!busy) begin
      flash_rsp.data <= ~flash_rsp.data;
      if (flash_req.req === 1'b1) begin
        busy <= 1'b1;
        cnt  <= lat;
      end
    end else if (cnt != 4'h0) begin
      cnt            <= cnt - 4'h1;
      flash_rsp.data <= ~flash_rsp.data;
    end else begin
      // present the word at the address held now
      busy            <= 1'b0;
      flash_rsp.valid <= 1'b1;
      flash_rsp.data  <= mem.exists(flash_req.addr) ? mem[flash_req.addr] : 32'hFFFF_FFFF;
    end
  end
endmodule
`default_nettype wire

// File: logic/bsl_boot_seq.sv
// boot sequencer and application image locator
// assumes supply levels, straps and flash answers synchronous to core_clk;
// the flash word reader outside holds an answer for one cycle per request
//
// Overview of operation
// - hold core reset until regulator valid
// - reset regs, load trims, settle, then address
// - target address from two strap pins
// - enable fast clock, wait persistent supply
// - enable thermal and peripheral blocks before addressing
// - open limited host interface after addressing
// - dead battery: main invalid, bus valid
// - dead battery samples power select, configures path
// - headers at 0x000000 and 0x001000
// - firmware at region pointer plus offset
// - validate pointers and application code first
// - fall back to intact region after bad update
// - slow clock runs core in low power
// - invalid memory exposes debug wire interface
`timescale 1ns/1ps
`default_nettype none
module bsl_boot_seq
  import bsl_pkg::*;
#(
  parameter logic [31:0] APP_SIGNATURE = 32'hA5C3_5A3C,  // arbitrary marker value
  parameter int          PERSIST      = PERSIST_CYC,
  parameter int          TRIM_WAIT    = TRIM_SETTLE_CYC
) (
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire bsl_pkg::bsl_supply_t    supplies,
  input  wire logic [1:0]              address_strap_pins,
  input  wire logic                    bus_power_path_select,
  input  wire logic                    low_power_req,
  input  wire bsl_pkg::bsl_flash_rsp_t flash_rsp,
  output logic                         core_reset,
  output logic                         regs_reset,
  output logic                         trim_load,
  output logic                         clk48_en,
  output logic                         slow_clk_sel,
  output bsl_pkg::bsl_periph_en_t      periph_en,
  output logic [6:0]                   target_address,
  output logic                         host_if_en,
  output logic                         dead_battery,
  output logic                         power_path_bus,
  output bsl_pkg::bsl_flash_req_t      flash_req,
  output logic [23:0]                  fw_base,
  output logic                         region_high,
  output logic                         boot_done,
  output logic                         invalid_memory,
  output logic                         debug_wire_en
);
  import bsl_pkg::*;

  localparam int TW = $clog2(TRIM_WAIT + 1);
  localparam logic [TW-1:0] TRIM_LAST = TW'(TRIM_WAIT - 1);

  // persistence filters for main and bus supply
  logic [1:0] sup_level;               // raw levels
  logic [1:0] sup_stable;              // filtered levels
  assign sup_level = {supplies.main_ok, supplies.bus_ok};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_persist
      bsl_persist #(.COUNT(PERSIST)) u_persist (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .level    (sup_level[g]),
        .stable   (sup_stable[g])
      );
    end
  endgenerate

  // sequencer state
  bsl_state_t              state, next_state;
  logic [TW-1:0]           tcnt, next_tcnt;           // trim settle timer
  logic [23:0]             region_pointer, next_region_pointer;          // header word 0
  logic [23:0]             application_offset, next_application_offset;  // header word 1
  logic                    next_region_high;
  logic                    next_core_reset, next_regs_reset, next_trim_load;
  logic                    next_clk48_en, next_slow_clk_sel;
  bsl_periph_en_t          next_periph_en;
  logic [6:0]              next_target_address;
  logic                    next_host_if_en, next_dead_battery, next_power_path_bus;
  bsl_flash_req_t          next_flash_req;
  logic [23:0]             next_fw_base;
  logic                    next_boot_done, next_invalid_memory, next_debug_wire_en;
  logic [23:0]             hdr_base;                  // header of region under test
  logic [23:0]             app_addr;                  // pointer plus offset

  assign hdr_base = region_high ? HDR_HIGH_ADDR : HDR_LOW_ADDR;
  assign app_addr = region_pointer + application_offset;

  // next-state and output computation
  always_comb begin
    next_state          = state;
    next_tcnt           = tcnt;
    next_region_pointer = region_pointer;
    next_application_offset = application_offset;
    next_region_high    = region_high;
    next_core_reset     = core_reset;
    next_regs_reset     = 1'b0;
    next_trim_load      = 1'b0;
    next_clk48_en       = clk48_en;
    next_slow_clk_sel   = slow_clk_sel;
    next_periph_en      = periph_en;
    next_target_address = target_address;
    next_host_if_en     = host_if_en;
    next_dead_battery   = dead_battery;
    next_power_path_bus = power_path_bus;
    next_flash_req      = flash_req;
    next_fw_base        = fw_base;
    next_boot_done      = boot_done;
    next_invalid_memory = invalid_memory;
    next_debug_wire_en  = debug_wire_en;
    case (state)
      // core held in reset until the regulator is valid
      ST_POR: begin
        next_core_reset = 1'b1;
        if (supplies.regulator_ok) begin
          next_core_reset = 1'b0;
          next_regs_reset = 1'b1;
          next_state      = ST_REGS;
        end
      end
      // internal registers reset, then trims loaded
      ST_REGS: begin
        next_trim_load = 1'b1;
        next_tcnt      = '0;
        next_state     = ST_TRIM;
      end
      // trim load pulse done, start settle timer
      ST_TRIM: begin
        next_state = ST_SETTLE;
      end
      // wait for trims to settle
      ST_SETTLE: begin
        if (tcnt == TRIM_LAST) begin
          next_clk48_en = 1'b1;
          next_state    = ST_SUPPLY;
        end else begin
          next_tcnt = tcnt + 1'b1;
        end
      end
      // hold until the powering supply is persistent
      ST_SUPPLY: begin
        if (|sup_stable) begin
          next_state = ST_PERIPH;
        end
      end
      // thermal, converter, crc, gpio and interrupt block together
      ST_PERIPH: begin
        next_periph_en = '1;
        next_state     = ST_ADDR;
      end
      // target address from the straps
      ST_ADDR: begin
        next_target_address = {TADDR_HI, address_strap_pins[1],
                               address_strap_pins[0], TADDR_LO};
        next_state          = ST_HOST;
      end
      // limited host interface once addressed
      ST_HOST: begin
        next_host_if_en = 1'b1;
        next_state      = ST_DBCHK;
      end
      // classify the boot cause
      ST_DBCHK: begin
        if (!supplies.main_ok && supplies.bus_ok) begin
          next_dead_battery = 1'b1;
          next_state        = ST_DBPATH;
        end else begin
          next_flash_req = '{req: 1'b1, addr: HDR_LOW_ADDR + HDR_PTR_OFS};
          next_state     = ST_HPTR;
        end
      end
      // dead battery: route power from the select pin
      ST_DBPATH: begin
        next_power_path_bus = !bus_power_path_select;
        next_flash_req      = '{req: 1'b1, addr: HDR_LOW_ADDR + HDR_PTR_OFS};
        next_state          = ST_HPTR;
      end
      // header region pointer word
      ST_HPTR: begin
        if (flash_rsp.valid) begin
          next_region_pointer = flash_rsp.data[23:0];
          next_flash_req      = '{req: 1'b1, addr: hdr_base + HDR_OFFSET_OFS};
          next_state     = ST_HOFF;
        end
      end
      // header offset word, then reject blank or null pointers
      ST_HOFF: begin
        if (flash_rsp.valid) begin
          next_application_offset = flash_rsp.data[23:0];
          if (region_pointer == ERASED_PTR || region_pointer == ZERO_PTR) begin
            next_flash_req.req = 1'b0;
            next_state         = ST_APPCHK;
          end else begin
            next_flash_req = '{req: 1'b1, addr: region_pointer + flash_rsp.data[23:0]};
            next_state     = ST_APPCHK;
          end
        end
      end
      // check application marker; fall back or give up
      ST_APPCHK: begin
        if (!flash_req.req || flash_rsp.valid) begin
          next_flash_req.req = 1'b0;
          if (flash_req.req && flash_rsp.data == APP_SIGNATURE) begin
            next_fw_base   = app_addr;
            next_boot_done = 1'b1;
            next_state     = ST_RUN;
          end else if (!region_high) begin
            next_region_high = 1'b1;
            next_flash_req   = '{req: 1'b1, addr: HDR_HIGH_ADDR + HDR_PTR_OFS};
            next_state       = ST_HPTR;
          end else begin
            next_invalid_memory = 1'b1;
            next_debug_wire_en  = 1'b1;
            next_state          = ST_INVALID;
          end
        end
      end
      // running: slow clock carries the core in low power
      ST_RUN: begin
        next_slow_clk_sel = low_power_req;
        next_clk48_en     = !low_power_req;
      end
      // stay here with debug wire exposed
      ST_INVALID: begin
        next_debug_wire_en = 1'b1;
      end
      default: begin
        next_state = ST_POR;
      end
    endcase
    // loss of the regulator restarts the whole boot
    if (!supplies.regulator_ok) begin
      next_state          = ST_POR;
      next_core_reset     = 1'b1;
      next_clk48_en       = 1'b0;
      next_slow_clk_sel   = 1'b0;
      next_periph_en      = '0;
      next_host_if_en     = 1'b0;
      next_flash_req      = '0;
      next_boot_done      = 1'b0;
      next_invalid_memory = 1'b0;
      next_debug_wire_en  = 1'b0;
      next_region_high    = 1'b0;
      next_dead_battery   = 1'b0;
      next_power_path_bus = 1'b0;
    end
  end

  // registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state          <= ST_POR;
      tcnt           <= '0;
      region_pointer <= '0;
      application_offset <= '0;
      region_high    <= 1'b0;
      core_reset     <= 1'b1;
      regs_reset     <= 1'b0;
      trim_load      <= 1'b0;
      clk48_en       <= 1'b0;
      slow_clk_sel   <= 1'b0;
      periph_en      <= '0;
      target_address <= '0;
      host_if_en     <= 1'b0;
      dead_battery   <= 1'b0;
      power_path_bus <= 1'b0;
      flash_req      <= '0;
      fw_base        <= '0;
      boot_done      <= 1'b0;
      invalid_memory <= 1'b0;
      debug_wire_en  <= 1'b0;
    end else begin
      state          <= next_state;
      tcnt           <= next_tcnt;
      region_pointer <= next_region_pointer;
      application_offset <= next_application_offset;
      region_high    <= next_region_high;
      core_reset     <= next_core_reset;
      regs_reset     <= next_regs_reset;
      trim_load      <= next_trim_load;
      clk48_en       <= next_clk48_en;
      slow_clk_sel   <= next_slow_clk_sel;
      periph_en      <= next_periph_en;
      target_address <= next_target_address;
      host_if_en     <= next_host_if_en;
      dead_battery   <= next_dead_battery;
      power_path_bus <= next_power_path_bus;
      flash_req      <= next_flash_req;
      fw_base        <= next_fw_base;
      boot_done      <= next_boot_done;
      invalid_memory <= next_invalid_memory;
      debug_wire_en  <= next_debug_wire_en;
    end
  end

  // checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_reg_load;
    regs_reset ##1 trim_load;
  endsequence

  a_reset_until_reg: assert property (!supplies.regulator_ok |=> core_reset)
    else $error("core left reset without regulator");
  a_regs_then_trim: assert property ($rose(regs_reset) |-> s_reg_load)
    else $error("trim load did not follow register reset");
  a_strap_address: assert property (state == ST_ADDR && supplies.regulator_ok |=>
    target_address == {TADDR_HI, $past(address_strap_pins), TADDR_LO})
    else $error("target address not from straps");
  a_clk_before_run: assert property ($rose(periph_en.intc) |-> clk48_en && |sup_stable)
    else $error("peripherals enabled before stable supply");
  a_host_after_addr: assert property ($rose(host_if_en) |-> $past(state, 2) == ST_ADDR)
    else $error("host interface opened before addressing");
  a_db_classify: assert property (state == ST_DBCHK && supplies.regulator_ok &&
    !supplies.main_ok && supplies.bus_ok |=> dead_battery ##1 state == ST_HPTR)
    else $error("dead battery boot not handled");
  a_first_header: assert property ($rose(flash_req.req) && !region_high |->
    flash_req.addr == HDR_LOW_ADDR)
    else $error("first header read not at low header");
  a_fw_is_sum: assert property ($rose(boot_done) |->
    fw_base == region_pointer + application_offset)
    else $error("firmware base not pointer plus offset");
  a_invalid_debug: assert property ($rose(invalid_memory) |->
    debug_wire_en && region_high && !boot_done)
    else $error("invalid flow without both regions failing");
  a_low_power_clk: assert property (state == ST_RUN && supplies.regulator_ok
    && low_power_req |=> slow_clk_sel && !clk48_en)
    else $error("low power did not move to slow clock");
endmodule
`default_nettype wire

// File: logic/bsl_persist.sv
// persistence filter: output rises once input held high for a full count
// assumes input synchronous to core_clk
`timescale 1ns/1ps
`default_nettype none
module bsl_persist #(
  parameter int COUNT = bsl_pkg::PERSIST_CYC  // cycles the input must stay high
) (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic level,
  output logic      stable
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] CMAX = CW'(COUNT);

  logic [CW-1:0] cnt;                // cycles seen high
  logic [CW-1:0] next_cnt;
  logic          next_stable;

  // count up while high, restart on any drop
  always_comb begin
    next_cnt    = cnt;
    next_stable = 1'b0;
    if (!level) begin
      next_cnt = '0;
    end else if (cnt != CMAX) begin
      next_cnt = cnt + 1'b1;
    end
    next_stable = level && (next_cnt == CMAX);
  end

  // registers
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cnt    <= '0;
      stable <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      stable <= next_stable;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  a_drop_clears_stable: assert property (!level |=> !stable)
    else $error("stable held after input drop");
  a_rise_needs_count: assert property ($rose(stable) |-> cnt == CMAX)
    else $error("stable rose before full count");
endmodule
`default_nettype wire

// File: shared/bsl_pkg.sv
// boot sequencer / image locator: shared constants, states and carriers
// assumes one 125 MHz core clock and synchronous active-low reset
package bsl_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS   = 8;      // core_clk period
  localparam int TRIM_SETTLE_NS  = 2000;   // least trim settle time
  localparam int TRIM_SETTLE_CYC = (TRIM_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERSIST_NS      = 4000;   // least time a supply must stay valid
  localparam int PERSIST_CYC     = (PERSIST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // flash layout
  localparam int             FL_AW        = 24;            // flash address width
  localparam int             FL_DW        = 32;            // flash word width
  localparam logic [23:0]    HDR_LOW_ADDR = 24'h00_0000;   // low header block
  localparam logic [23:0]    HDR_HIGH_ADDR = 24'h00_1000;  // high header block
  localparam logic [23:0]    HDR_PTR_OFS  = 24'h00_0000;   // region pointer word
  localparam logic [23:0]    HDR_OFFSET_OFS = 24'h00_0004; // application offset word
  localparam logic [23:0]    ERASED_PTR   = 24'hFF_FFFF;   // blank flash pointer
  localparam logic [23:0]    ZERO_PTR     = 24'h00_0000;   // null pointer

  // target address layout {01, strap2, strap1, 111}
  localparam logic [1:0]     TADDR_HI     = 2'h1;
  localparam logic [2:0]     TADDR_LO     = 3'h7;

  // sequencer states
  typedef enum logic [3:0] {
    ST_POR, ST_REGS, ST_TRIM, ST_SETTLE, ST_SUPPLY, ST_PERIPH, ST_ADDR,
    ST_HOST, ST_DBCHK, ST_DBPATH, ST_HPTR, ST_HOFF, ST_APPCHK, ST_RUN, ST_INVALID
  } bsl_state_t;

  // supply monitor levels
  typedef struct packed {
    logic regulator_ok;   // internal_regulator_out valid
    logic main_ok;        // main_supply_input valid
    logic bus_ok;         // bus supply valid
  } bsl_supply_t;

  // peripheral enables
  typedef struct packed {
    logic thermal;
    logic tsd;
    logic adc;
    logic crc;
    logic gpio;
    logic intc;           // interrupt_controller_block
  } bsl_periph_en_t;

  // flash word read request and answer
  typedef struct packed {
    logic             req;
    logic [FL_AW-1:0] addr;
  } bsl_flash_req_t;

  typedef struct packed {
    logic             valid;
    logic [FL_DW-1:0] data;
  } bsl_flash_rsp_t;

endpackage
